/* verilog/adc_ctrl_defs.svh */
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// register offsets
`define OFS_RESULT_LO 8'h78
`define OFS_RESULT_HI 8'h79
`define OFS_CTRL_A 8'h7a
`define OFS_CTRL_B 8'h7b
`define OFS_INREF 8'h7c
`define OFS_TEST 8'h7d
`define OFS_DDIS 8'h7e
`define OFS_IRQ_STATUS 8'h70
`define OFS_IRQ_CLEAR 8'h71
`define OFS_IRQ_ENABLE 8'h72

// reset values
`define RST_BYTE 8'h00
`define RST_CTRL_A 8'h00

// control a fields
`define CA_ENABLE 7
`define CA_START 6
`define CA_AUTO 5
// control b fields
`define CB_CMP1_NEG_HI 5
`define CB_CMP1_NEG_LO 4
`define CB_CMP_CH 3
`define CB_TRIG_HI 2
`define CB_TRIG_LO 0
`define CB_MASK 8'h3f
// input/reference fields
`define IR_REF_HI 7
`define IR_REF_LO 6
`define IR_LADJ 5
`define IR_CH_HI 4
`define IR_CH_LO 0
// test mode field
`define TM_REF_OUT 0
`define TM_MASK 8'h01
// interrupt status bits
`define IRQ_DONE 0
`define IRQ_TRIG 1
`define IRQ_MASK 8'h03

// trigger source codes
`define TRG_CONTINUOUS 3'h0
`define TRG_CMP 3'h1
`define TRG_EXT0 3'h2
`define TRG_T0_CMP 3'h3
`define TRG_T0_OVF 3'h4
`define TRG_T1_CMPB 3'h5
`define TRG_T1_OVF 3'h6
`define TRG_T1_CAPT 3'h7

`endif

/* verilog/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;
  typedef enum logic [1:0] {REF_EXT_PIN, REF_SUPPLY, REF_2V56, REF_1V25} ref_sel_t;
  typedef enum logic [1:0] {NEG_EXT_PIN, NEG_MUX_OUT, NEG_AMP1, NEG_AMP1_B} cmp1_neg_t;
endpackage

/* verilog/adc_trig_edge.sv */
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_trig_edge
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [2:0] i_source,
  input wire logic i_cmp_channel,
  input wire logic i_cmp0_out,
  input wire logic i_cmp1_out,
  input wire logic i_ext0_flag,
  input wire logic i_t0_cmp_flag,
  input wire logic i_t0_ovf_flag,
  input wire logic i_t1_cmpb_flag,
  input wire logic i_t1_ovf_flag,
  input wire logic i_t1_capt_flag,
  output logic o_edge
);
  logic sel;
  logic prev_q;
  logic prev_d;
  logic edge_q;
  logic edge_d;

  // pick the flag of the selected source; code zero has no event source
  always_comb
  begin
    unique case (i_source)
      `TRG_CMP: sel = i_cmp_channel ? i_cmp1_out : i_cmp0_out;
      `TRG_EXT0: sel = i_ext0_flag;
      `TRG_T0_CMP: sel = i_t0_cmp_flag;
      `TRG_T0_OVF: sel = i_t0_ovf_flag;
      `TRG_T1_CMPB: sel = i_t1_cmpb_flag;
      `TRG_T1_OVF: sel = i_t1_ovf_flag;
      `TRG_T1_CAPT: sel = i_t1_capt_flag;
      default: sel = 1'b0;
    endcase
    prev_d = sel;
    edge_d = sel & ~prev_q;
  end

  // a source switch may itself look like an edge; software should switch while idle
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      edge_q <= edge_d;
    end
  end

  assign o_edge = edge_q;
endmodule

/* verilog/adc_result_align.sv */
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_result_align #(
  parameter int RESULT_W = 12
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic i_left,
  input wire logic [RESULT_W-1:0] i_result,
  output logic [15:0] o_pair
);
  logic [15:0] pair_q;
  logic [15:0] pair_d;

  // the result has to fit the byte pair it is aligned into
  if (RESULT_W < 1 || RESULT_W > 16)
  begin
    $error("result width out of range");
  end

  // left aligned leaves the low bits zero, right aligned the high bits
  always_comb
  begin
    pair_d = pair_q;
    if (i_load)
    begin
      if (i_left)
        pair_d = {i_result, {(16-RESULT_W){1'b0}}};
      else
        pair_d = {{(16-RESULT_W){1'b0}}, i_result};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pair_q <= 16'h0000;
    else
      pair_q <= pair_d;
  end

  assign o_pair = pair_q;
endmodule

/* verilog/adc_trigger_mux_control.sv */
// How it works
// - comparator 1 negative input: 00 external pin, 01 converter mux output, 1x amplifier 1.
// - comparator trigger channel picks comparator 0 when 0 and comparator 1 when 1.
// - trigger source field does nothing unless auto-trigger enable is set.
// - a clear-to-set change of the selected flag starts one conversion if enabled.
// - source zero is continuous conversion and ignores external trigger events.
// - sources 1..7 are comparator, ext int 0, t0 compare, t0 overflow, t1 cmp b, ovf, capture.
// - a reference change during a conversion takes effect only after it completes.
// - reference codes 0..3 select external pin, supply, 2.56V and 1.25V sources.
// - left-adjust bit 1 stores the result left justified, else right justified.
// - channel codes 0-7 pins, 8 quarter supply, 13 amplifier 0, 14 reference, 15 ground.
// - the test-mode bit drives the internal reference onto the reference pin.
// - a disable bit set forces the digital reading of its analog pin to zero.
// - conversion done sets the done flag and updates the result; it may serve as trigger.
// - auto-trigger enable lets the selected source start conversions, else only software.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_trigger_mux_control #(
  parameter int RESULT_W = 12
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_cmp0_out,
  input wire logic i_cmp1_out,
  input wire logic i_ext0_flag,
  input wire logic i_t0_cmp_flag,
  input wire logic i_t0_ovf_flag,
  input wire logic i_t1_cmpb_flag,
  input wire logic i_t1_ovf_flag,
  input wire logic i_t1_capt_flag,
  input wire logic i_conv_done,
  input wire logic [RESULT_W-1:0] i_conv_result,
  input wire logic [7:0] i_pin_din,
  output logic o_conv_start,
  output logic o_converter_enable,
  output logic [1:0] o_reference_select,
  output logic [4:0] o_input_channel_select,
  output logic [1:0] o_cmp1_negative_select,
  output logic o_reference_test_out,
  output logic [7:0] o_pin_din,
  output logic o_irq
);
  if (RESULT_W < 1 || RESULT_W > 16)
  begin
    $error("result width out of range");
  end
  default clocking cb_sva @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] ctrl_a_q, ctrl_a_d;
  logic [7:0] ctrl_b_q, ctrl_b_d;
  logic [7:0] inref_q, inref_d;
  logic [7:0] test_q, test_d;
  logic [7:0] ddis_q, ddis_d;
  logic [7:0] irq_st_q, irq_st_d;
  logic [7:0] irq_en_q, irq_en_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] result_pair;
  logic trig_edge;
  logic start_now;
  logic done_now;

  // software writes; reserved bits are masked so they stay zero
  always_comb
  begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    inref_d = inref_q;
    test_d = test_q;
    ddis_d = ddis_q;
    irq_en_d = irq_en_q;
    irq_st_d = irq_st_q;
    if (start_now)
      ctrl_a_d[`CA_START] = 1'b0;
    if (i_wr)
    begin
      if (hit(i_addr, `OFS_CTRL_A))
        ctrl_a_d = {i_wdata[7:5], 5'h00} | {1'b0, ctrl_a_d[`CA_START], 6'h00};
      if (hit(i_addr, `OFS_CTRL_B))
        ctrl_b_d = i_wdata & `CB_MASK;
      if (hit(i_addr, `OFS_INREF))
        inref_d = i_wdata;
      if (hit(i_addr, `OFS_TEST))
        test_d = i_wdata & `TM_MASK;
      if (hit(i_addr, `OFS_DDIS))
        ddis_d = i_wdata;
      if (hit(i_addr, `OFS_IRQ_ENABLE))
        irq_en_d = i_wdata & `IRQ_MASK;
      if (hit(i_addr, `OFS_IRQ_CLEAR))
        irq_st_d = irq_st_q & ~i_wdata;
    end
    // events win over a clear in the same cycle
    if (done_now)
      irq_st_d[`IRQ_DONE] = 1'b1;
    if (start_now && ctrl_a_q[`CA_AUTO])
      irq_st_d[`IRQ_TRIG] = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_a_q <= `RST_CTRL_A;
      ctrl_b_q <= `RST_BYTE;
      inref_q <= `RST_BYTE;
      test_q <= `RST_BYTE;
      ddis_q <= `RST_BYTE;
      irq_st_q <= `RST_BYTE;
      irq_en_q <= `RST_BYTE;
    end
    else
    begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      inref_q <= inref_d;
      test_q <= test_d;
      ddis_q <= ddis_d;
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stand one cycle after the strobe, unmapped reads zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        `OFS_RESULT_LO: rdata_d = result_pair[7:0];
        `OFS_RESULT_HI: rdata_d = result_pair[15:8];
        `OFS_CTRL_A: rdata_d = ctrl_a_q;
        `OFS_CTRL_B: rdata_d = ctrl_b_q;
        `OFS_INREF: rdata_d = inref_q;
        `OFS_TEST: rdata_d = test_q;
        `OFS_DDIS: rdata_d = ddis_q;
        `OFS_IRQ_STATUS: rdata_d = irq_st_q;
        `OFS_IRQ_ENABLE: rdata_d = irq_en_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger edge detection on the selected source
  adc_trig_edge u_edge (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_source(ctrl_b_q[`CB_TRIG_HI:`CB_TRIG_LO]),
    .i_cmp_channel(ctrl_b_q[`CB_CMP_CH]),
    .i_cmp0_out(i_cmp0_out),
    .i_cmp1_out(i_cmp1_out),
    .i_ext0_flag(i_ext0_flag),
    .i_t0_cmp_flag(i_t0_cmp_flag),
    .i_t0_ovf_flag(i_t0_ovf_flag),
    .i_t1_cmpb_flag(i_t1_cmpb_flag),
    .i_t1_ovf_flag(i_t1_ovf_flag),
    .i_t1_capt_flag(i_t1_capt_flag),
    .o_edge(trig_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing
  adc_ctrl_pkg::conv_state_t state_q, state_d;
  logic start_q, start_d;
  logic [1:0] ref_q, ref_d;
  logic [4:0] chan_q, chan_d;
  logic ladj_q, ladj_d;
  logic auto_go;
  logic continuous;

  assign done_now = (state_q == adc_ctrl_pkg::ST_CONV) && i_conv_done;
  assign continuous = ctrl_b_q[`CB_TRIG_HI:`CB_TRIG_LO] == `TRG_CONTINUOUS;
  // source field only matters with auto trigger on; continuous restarts on completion
  assign auto_go = ctrl_a_q[`CA_AUTO] && (continuous ? done_now : trig_edge);
  assign start_now = ctrl_a_q[`CA_ENABLE] && (state_q == adc_ctrl_pkg::ST_IDLE || done_now)
                     && (ctrl_a_q[`CA_START] || auto_go);

  // mux and reference settings follow the register while idle and are held from start until done
  always_comb
  begin
    state_d = state_q;
    ref_d = ref_q;
    chan_d = chan_q;
    ladj_d = ladj_q;
    start_d = start_now;
    if (state_q == adc_ctrl_pkg::ST_IDLE || done_now)
    begin
      ref_d = inref_q[`IR_REF_HI:`IR_REF_LO];
      chan_d = inref_q[`IR_CH_HI:`IR_CH_LO];
      ladj_d = inref_q[`IR_LADJ];
    end
    unique case (state_q)
      adc_ctrl_pkg::ST_IDLE:
        if (start_now)
          state_d = adc_ctrl_pkg::ST_CONV;
      adc_ctrl_pkg::ST_CONV:
        if (!ctrl_a_q[`CA_ENABLE])
          state_d = adc_ctrl_pkg::ST_IDLE;
        else if (done_now && !start_now)
          state_d = adc_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      start_q <= 1'b0;
      ref_q <= 2'h0;
      chan_q <= 5'h00;
      ladj_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      start_q <= start_d;
      ref_q <= ref_d;
      chan_q <= chan_d;
      ladj_q <= ladj_d;
    end
  end

  // result is captured with the alignment of the running conversion
  adc_result_align #(.RESULT_W(RESULT_W)) u_align (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_load(done_now),
    .i_left(ladj_q),
    .i_result(i_conv_result),
    .o_pair(result_pair)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered pin-facing outputs
  logic en_q;
  logic [1:0] neg_q;
  logic tm_q;
  logic [7:0] din_q, din_d;
  logic irq_q;

  assign din_d = i_pin_din & ~ddis_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      en_q <= 1'b0;
      neg_q <= 2'h0;
      tm_q <= 1'b0;
      din_q <= 8'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      en_q <= ctrl_a_d[`CA_ENABLE];
      neg_q <= ctrl_b_d[`CB_CMP1_NEG_HI:`CB_CMP1_NEG_LO];
      tm_q <= test_d[`TM_REF_OUT];
      din_q <= din_d;
      irq_q <= |(irq_st_d & irq_en_d);
    end
  end

  assign o_rdata = rdata_q;
  assign o_conv_start = start_q;
  assign o_converter_enable = en_q;
  assign o_reference_select = ref_q;
  assign o_input_channel_select = chan_q;
  assign o_cmp1_negative_select = neg_q;
  assign o_reference_test_out = tm_q;
  assign o_pin_din = din_q;
  assign o_irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks; clock and reset come from the defaults at the top of the module
  property p_ref_hold;
    (state_q == adc_ctrl_pkg::ST_CONV && !done_now) |=> $stable(o_reference_select);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference moved mid conversion");
  property p_edge_start;
    (trig_edge && ctrl_a_q[`CA_AUTO] && !continuous && ctrl_a_q[`CA_ENABLE]
     && state_q == adc_ctrl_pkg::ST_IDLE) |=> o_conv_start;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("trigger edge did not start");
  property p_no_auto_off;
    (!ctrl_a_q[`CA_AUTO] && !ctrl_a_q[`CA_START]) |=> !o_conv_start;
  endproperty
  a_no_auto_off: assert property (p_no_auto_off) else $error("start without cause");
  property p_need_enable;
    !ctrl_a_q[`CA_ENABLE] |=> !o_conv_start;
  endproperty
  a_need_enable: assert property (p_need_enable) else $error("start while disabled");
  property p_cont_ignores;
    (continuous && !ctrl_a_q[`CA_START] && !done_now) |=> !o_conv_start;
  endproperty
  a_cont_ignores: assert property (p_cont_ignores) else $error("event in continuous");
  // the interrupt level is registered from the same next values, so it rises with the flag
  property p_done_flag;
    done_now |=> irq_st_q[`IRQ_DONE] && (!irq_en_q[`IRQ_DONE] || o_irq);
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag not set");
  property p_din_gate;
    ##1 ((o_pin_din & $past(ddis_q)) == 8'h00);
  endproperty
  a_din_gate: assert property (p_din_gate) else $error("disabled pin leaked");
  property p_test_rsvd;
    (test_q[7:1] == 7'h00) && (ctrl_b_q[7:6] == 2'h0);
  endproperty
  a_test_rsvd: assert property (p_test_rsvd) else $error("reserved bit set");
  property p_left_align;
    (done_now && ladj_q) |=> result_pair[15:16-RESULT_W] == $past(i_conv_result);
  endproperty
  a_left_align: assert property (p_left_align) else $error("left alignment wrong");
endmodule

/* dv/adc_core_model.sv */
`timescale 1ns/1ps
module adc_core_model
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [3:0] i_delay,
  input wire logic [11:0] i_value,
  output logic o_done,
  output logic [11:0] o_result
);
  logic [3:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  // countdown from each start; result bus toggles outside done so a capture one cycle late reads inverted data
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_q <= 4'h0;
      o_done <= 1'b0;
      o_result <= 12'h000;
    end
    else
    begin
      o_done <= (cnt_q == 4'h1);
      o_result <= (cnt_q == 4'h1) ? i_value : ~o_result;
      if (i_start)
        cnt_q <= i_delay;
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

/* dv/adc_trigger_mux_control_bench.sv */
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_trigger_mux_control_bench;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] trig = 8'h00;
  logic [7:0] i_pin_din = 8'ha5;
  logic [3:0] delay = 4'h4;
  logic [11:0] value = 12'habc;
  logic [7:0] o_rdata;
  logic [7:0] o_pin_din;
  logic o_conv_start, o_converter_enable, o_reference_test_out, o_irq, done;
  logic [1:0] o_reference_select;
  logic [1:0] o_cmp1_negative_select;
  logic [4:0] o_input_channel_select;
  logic [11:0] result;
  logic [4:0] chtab [0:5] = '{5'h00, 5'h07, 5'h08, 5'h0d, 5'h0e, 5'h0f};
  int fail_count = 0;
  int cmp_count = 0;
  int starts = 0;
  int base;
  logic [2:0] src;

  // free-running bench clock, 25 ns period
  always #12.5 i_clk = ~i_clk;

  adc_trigger_mux_control u_adc_trigger_mux_control (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cmp0_out(trig[0]), .i_cmp1_out(trig[1]), .i_ext0_flag(trig[2]),
    .i_t0_cmp_flag(trig[3]), .i_t0_ovf_flag(trig[4]), .i_t1_cmpb_flag(trig[5]),
    .i_t1_ovf_flag(trig[6]), .i_t1_capt_flag(trig[7]), .i_conv_done(done),
    .i_conv_result(result), .i_pin_din(i_pin_din), .o_conv_start(o_conv_start),
    .o_converter_enable(o_converter_enable), .o_reference_select(o_reference_select),
    .o_input_channel_select(o_input_channel_select),
    .o_cmp1_negative_select(o_cmp1_negative_select),
    .o_reference_test_out(o_reference_test_out), .o_pin_din(o_pin_din), .o_irq(o_irq));

  adc_core_model u_adc_core_model (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_start(o_conv_start), .i_delay(delay), .i_value(value), .o_done(done),
    .o_result(result));

  ////////////////////////////////////////////////////////////////////////////
  // count every start pulse so tests compare deltas instead of exact edges
  always @(posedge i_clk)
    if (o_conv_start === 1'b1)
      starts <= starts + 1;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t value mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe, released at the following edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so look just past that edge
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk({8'h00, o_rdata & m}, {8'h00, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic pulse(input int k);
    @(posedge i_clk);
    trig[k] <= 1'b1;
    cyc(3);
    trig[k] <= 1'b0;
    cyc(20);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the roughly 600 cycles the tests need
  initial
  begin
    cyc(20000);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    cyc(12);
    i_reset_n <= 1'b1;
    rd(`OFS_INREF, 8'hff, 8'h00);
    rd(`OFS_TEST, 8'hff, 8'h00);
    rd(`OFS_DDIS, 8'hff, 8'h00);
    rd(8'h00, 8'hff, 8'h00);
    wr(`OFS_TEST, 8'hff);
    rd(`OFS_TEST, 8'hff, 8'h01);
    chk(16'(o_reference_test_out), 16'h1);
    wr(`OFS_TEST, 8'h00);
    cyc(2);
    chk(16'(o_reference_test_out), 16'h0);
    wr(`OFS_CTRL_B, 8'hff);
    rd(`OFS_CTRL_B, 8'hff, 8'h3f);
    $display("test registers finished");
    wr(`OFS_DDIS, 8'h0f);
    cyc(2);
    chk(16'(o_pin_din), 16'h00a0);
    wr(`OFS_DDIS, 8'h00);
    cyc(2);
    chk(16'(o_pin_din), 16'h00a5);
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_CTRL_B, {2'b00, i[1:0], 4'h0});
      cyc(2);
      chk(16'(o_cmp1_negative_select), 16'(i));
    end
    for (int i = 0; i < 6; i++)
    begin
      wr(`OFS_INREF, {i[1:0], 1'b0, chtab[i]});
      cyc(3);
      chk(16'(o_reference_select), 16'(i[1:0]));
      chk(16'(o_input_channel_select), 16'(chtab[i]));
    end
    $display("test selects finished");
    // every auto source; comparator source first gets a pulse on the unselected comparator
    wr(`OFS_CTRL_A, 8'ha0);
    cyc(2);
    chk(16'(o_converter_enable), 16'h1);
    for (int k = 0; k < 8; k++)
    begin
      src = (k < 2) ? 3'h1 : 3'(k);
      wr(`OFS_CTRL_B, {4'h0, k == 1, src});
      base = starts;
      if (k < 2)
        pulse(k ^ 1);
      chk(16'(starts - base), 16'h0);
      pulse(k);
      chk(16'(starts - base), 16'h1);
    end
    wr(`OFS_CTRL_A, 8'h80);
    wr(`OFS_CTRL_B, 8'h02);
    base = starts;
    pulse(2);
    chk(16'(starts - base), 16'h0);
    wr(`OFS_CTRL_A, 8'hc0);
    cyc(20);
    chk(16'(starts - base), 16'h1);
    wr(`OFS_CTRL_B, 8'h00);
    wr(`OFS_CTRL_A, 8'ha0);
    base = starts;
    pulse(2);
    chk(16'(starts - base), 16'h0);
    wr(`OFS_CTRL_A, 8'he0);
    cyc(40);
    wr(`OFS_CTRL_A, 8'h80);
    chk(16'(starts - base > 2), 16'h1);
    cyc(20);
    $display("test triggers finished");
    // slow core so a reference change lands mid conversion
    delay <= 4'hc;
    rd(`OFS_IRQ_STATUS, 8'h03, 8'h03);
    wr(`OFS_IRQ_CLEAR, 8'h03);
    wr(`OFS_IRQ_ENABLE, 8'h01);
    wr(`OFS_INREF, 8'h41);
    cyc(2);
    chk(16'(o_irq), 16'h0);
    wr(`OFS_CTRL_A, 8'hc0);
    cyc(4);
    wr(`OFS_INREF, 8'ha3);
    cyc(2);
    chk(16'(o_reference_select), 16'h1);
    cyc(20);
    chk(16'(o_reference_select), 16'h2);
    rd(`OFS_IRQ_STATUS, 8'h03, 8'h01);
    chk(16'(o_irq), 16'h1);
    rd(`OFS_RESULT_LO, 8'hff, 8'hbc);
    rd(`OFS_RESULT_HI, 8'hff, 8'h0a);
    wr(`OFS_IRQ_CLEAR, 8'h01);
    cyc(2);
    chk(16'(o_irq), 16'h0);
    wr(`OFS_IRQ_ENABLE, 8'h00);
    wr(`OFS_CTRL_A, 8'hc0);
    cyc(25);
    chk(16'(o_irq), 16'h0);
    rd(`OFS_IRQ_STATUS, 8'h03, 8'h01);
    rd(`OFS_RESULT_LO, 8'hff, 8'hc0);
    rd(`OFS_RESULT_HI, 8'hff, 8'hab);
    $display("test conversion finished");
    tally_and_finish();
  end
endmodule
